// file: rtl/csft_core.v
// Status word, decimal arithmetic, multiply/divide and internal clock rate of
// an 8-bit core, reached over APB. Oscillator inputs are synchronous enables.
`timescale 1ns/100ps
`include "csft_consts.vh"
module csft_core (
  // Clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // Oscillator tick enables
  input wire main_oscillator_input_i,
  input wire sub_oscillator_input_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Core side
  input wire irq_req_i,
  output wire irq_take_o,
  output wire phi_en_o,
  output reg busy_o,
  output reg [7:0] port_dir_o
);
  reg [7:0] stat_q;
  reg [7:0] acc_q;
  reg [7:0] opnd_q;
  reg [7:0] hi_q;
  reg [7:0] sp_q;
  reg [7:0] stack_q [0:255];
  reg [1:0] mode_q;
  reg [3:0] div_q;
  reg [3:0] cyc_q;
  reg [3:0] op_q;
  reg [31:0] ticks_q;
  reg phi_q;
  wire wr_en;
  wire rd_en;
  wire osc_tick;
  wire [3:0] div_lim;
  wire [8:0] bin_sum;
  wire [8:0] bin_dif;
  wire [4:0] lo_add;
  wire [4:0] lo_sub;
  reg [8:0] dec_sum;
  reg [8:0] dec_dif;
  wire [15:0] product;
  wire [7:0] quot;
  wire [7:0] remd;
  reg [7:0] stat_d;
  reg [7:0] acc_d;
  reg [7:0] hi_d;
  reg [7:0] sp_d;

  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_en = psel_i & penable_i & ~pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;

  // The low-speed mode counts sub oscillator ticks, the others main ticks.
  assign osc_tick = (mode_q == `CSFT_MODE_LOW) ? sub_oscillator_input_i :
                    main_oscillator_input_i;
  assign div_lim = (mode_q == `CSFT_MODE_MID) ? `CSFT_DIV_MID :
                   (mode_q == `CSFT_MODE_LOW) ? `CSFT_DIV_LOW : `CSFT_DIV_HIGH;
  assign phi_en_o = phi_q;

  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      div_q <= 4'h0;
      phi_q <= 1'b0;
    end
    else
    begin
      phi_q <= 1'b0;
      if (osc_tick)
      begin
        if (div_q + 4'h1 >= div_lim)
        begin
          div_q <= 4'h0;
          phi_q <= 1'b1;
        end
        else
        begin
          div_q <= div_q + 4'h1;
        end
      end
    end
  end

  // Binary results; decimal results adjust nibble by nibble.
  assign bin_sum = {1'b0, acc_q} + {1'b0, opnd_q} + {8'h00, stat_q[`CSFT_C]};
  assign bin_dif = {1'b0, acc_q} - {1'b0, opnd_q} - {8'h00, ~stat_q[`CSFT_C]};
  assign lo_add = {1'b0, acc_q[3:0]} + {1'b0, opnd_q[3:0]} + {4'h0, stat_q[`CSFT_C]};
  assign lo_sub = {1'b0, acc_q[3:0]} - {1'b0, opnd_q[3:0]} - {4'h0, ~stat_q[`CSFT_C]};

  always @*
  begin
    dec_sum = bin_sum;
    if (lo_add > 5'h09)
    begin
      dec_sum = bin_sum + 9'h006;
    end
    if (dec_sum[8:4] > 5'h09)
    begin
      dec_sum = dec_sum + 9'h060;
    end
    dec_dif = bin_dif;
    if (lo_sub[4])
    begin
      dec_dif = dec_dif - 9'h006;
    end
    if (bin_dif[8])
    begin
      dec_dif = dec_dif - 9'h060;
    end
  end

  // Multiply and divide read no mode flags at all.
  assign product = acc_q * opnd_q;
  assign quot = (opnd_q == 8'h00) ? 8'hff : acc_q / opnd_q;
  assign remd = (opnd_q == 8'h00) ? acc_q : acc_q % opnd_q;

  always @*
  begin
    stat_d = stat_q;
    acc_d = acc_q;
    hi_d = hi_q;
    sp_d = sp_q;
    case (op_q)
      `CSFT_OP_ADC:
      begin
        if (stat_q[`CSFT_D])
        begin
          acc_d = dec_sum[7:0];
          stat_d[`CSFT_C] = dec_sum[8] | (dec_sum[7:4] > 4'h9);
          // Negative and zero follow the binary sum, so are not valid; overflow keeps its value.
          stat_d[`CSFT_Z] = (bin_sum[7:0] == 8'h00);
          stat_d[`CSFT_N] = bin_sum[7];
        end
        else
        begin
          acc_d = bin_sum[7:0];
          stat_d[`CSFT_C] = bin_sum[8];
          stat_d[`CSFT_Z] = (bin_sum[7:0] == 8'h00);
          stat_d[`CSFT_N] = bin_sum[7];
          stat_d[`CSFT_V] = (acc_q[7] == opnd_q[7]) & (bin_sum[7] != acc_q[7]);
        end
      end
      `CSFT_OP_SUB:
      begin
        acc_d = stat_q[`CSFT_D] ? dec_dif[7:0] : bin_dif[7:0];
        stat_d[`CSFT_C] = ~bin_dif[8];
        stat_d[`CSFT_Z] = (bin_dif[7:0] == 8'h00);
        stat_d[`CSFT_N] = bin_dif[7];
        stat_d[`CSFT_V] = (acc_q[7] != opnd_q[7]) & (bin_dif[7] != acc_q[7]);
      end
      `CSFT_OP_SETD: stat_d[`CSFT_D] = 1'b1;
      `CSFT_OP_CLRD: stat_d[`CSFT_D] = 1'b0;
      `CSFT_OP_SETC: stat_d[`CSFT_C] = 1'b1;
      `CSFT_OP_CLRC: stat_d[`CSFT_C] = 1'b0;
      `CSFT_OP_CLI: stat_d[`CSFT_I] = 1'b0;
      `CSFT_OP_SEI: stat_d[`CSFT_I] = 1'b1;
      `CSFT_OP_MULT:
      begin
        acc_d = product[7:0];
        hi_d = product[15:8];
      end
      `CSFT_OP_DIV:
      begin
        acc_d = quot;
        hi_d = remd;
      end
      `CSFT_OP_PUSH: sp_d = sp_q - 8'h01;
      `CSFT_OP_PULL:
      begin
        sp_d = sp_q + 8'h01;
        stat_d = stack_q[sp_q + 8'h01];
      end
      default: stat_d = stat_q;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (busy_o && phi_q && cyc_q == 4'h1 && op_q == `CSFT_OP_PUSH)
    begin
      stack_q[sp_q] <= stat_q;
    end
  end

  // An operation is accepted only while idle and retires on a phi boundary,
  // so it ends on the second phi pulse after it is accepted.
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stat_q <= `CSFT_STATUS_RESET;
      acc_q <= 8'h00;
      opnd_q <= 8'h00;
      hi_q <= 8'h00;
      sp_q <= `CSFT_SP_RESET;
      mode_q <= `CSFT_MODE_HIGH;
      op_q <= 4'h0;
      cyc_q <= 4'h0;
      busy_o <= 1'b0;
      ticks_q <= 32'h0000_0000;
      port_dir_o <= 8'h00;
    end
    else
    begin
      if (phi_q)
      begin
        ticks_q <= ticks_q + 32'h0000_0001;
      end
      if (busy_o && phi_q)
      begin
        if (cyc_q == 4'h1)
        begin
          stat_q <= stat_d;
          acc_q <= acc_d;
          hi_q <= hi_d;
          sp_q <= sp_d;
          busy_o <= 1'b0;
        end
        cyc_q <= cyc_q - 4'h1;
      end
      if (wr_en)
      begin
        case (paddr_i)
          `CSFT_ADDR_CTRL:
          begin
            mode_q <= pwdata_i[9:8];
            if (!busy_o && pwdata_i[3:0] != 4'h0)
            begin
              op_q <= pwdata_i[3:0];
              cyc_q <= `CSFT_OP_CYCLES;
              busy_o <= 1'b1;
            end
          end
          `CSFT_ADDR_OPND:
          begin
            opnd_q <= pwdata_i[7:0];
          end
          `CSFT_ADDR_RESULT:
          begin
            if (!busy_o)
            begin
              acc_q <= pwdata_i[7:0];
            end
          end
          `CSFT_ADDR_DIR:
          begin
            port_dir_o <= pwdata_i[7:0];
          end
          default:
          begin
            op_q <= op_q;
          end
        endcase
      end
    end
  end

  assign irq_take_o = irq_req_i & ~stat_q[`CSFT_I];

  always @*
  begin
    prdata_o = 32'h0000_0000;
    if (rd_en)
    begin
      case (paddr_i)
        `CSFT_ADDR_CTRL: prdata_o = {22'h0, mode_q, 3'h0, busy_o, op_q};
        `CSFT_ADDR_STATUS: prdata_o = {24'h0, stat_q};
        `CSFT_ADDR_OPND: prdata_o = {24'h0, opnd_q};
        `CSFT_ADDR_RESULT: prdata_o = {16'h0, hi_q, acc_q};
        `CSFT_ADDR_DIR: prdata_o = 32'h0000_0000;
        `CSFT_ADDR_SP: prdata_o = {24'h0, sp_q};
        `CSFT_ADDR_STACK: prdata_o = {24'h0, stack_q[sp_q + 8'h01]};
        `CSFT_ADDR_TICKS: prdata_o = ticks_q;
        `CSFT_ADDR_IRQ: prdata_o = {31'h0, ~stat_q[`CSFT_I]};
        default: prdata_o = 32'h0000_0000;
      endcase
    end
  end
endmodule // csft_core

// file: inc/csft_consts.vh
// Constants for the status-flag, decimal arithmetic and clock-rate block.
// Included by rtl/csft_core.v; definitions only.
`ifndef CSFT_CONSTS_VH
`define CSFT_CONSTS_VH
`define CSFT_ADDR_CTRL 12'h000
`define CSFT_ADDR_STATUS 12'h004
`define CSFT_ADDR_OPND 12'h008
`define CSFT_ADDR_RESULT 12'h00c
`define CSFT_ADDR_DIR 12'h010
`define CSFT_ADDR_SP 12'h014
`define CSFT_ADDR_STACK 12'h018
`define CSFT_ADDR_TICKS 12'h01c
`define CSFT_ADDR_IRQ 12'h020
// Status word bit positions.
`define CSFT_C 0
`define CSFT_Z 1
`define CSFT_I 2
`define CSFT_D 3
`define CSFT_B 4
`define CSFT_T 5
`define CSFT_V 6
`define CSFT_N 7
`define CSFT_STATUS_RESET 8'h04
`define CSFT_SP_RESET 8'hff
// Operation codes written to the control register.
`define CSFT_OP_ADC 4'h1
`define CSFT_OP_SUB 4'h2
`define CSFT_OP_SETD 4'h3
`define CSFT_OP_CLRD 4'h4
`define CSFT_OP_SETC 4'h5
`define CSFT_OP_CLRC 4'h6
`define CSFT_OP_MULT 4'h7
`define CSFT_OP_DIV 4'h8
`define CSFT_OP_PUSH 4'h9
`define CSFT_OP_PULL 4'ha
`define CSFT_OP_CLI 4'hb
`define CSFT_OP_SEI 4'hc
// Internal clock dividers in oscillator ticks: sub ticks in low mode, main ticks otherwise.
`define CSFT_DIV_HIGH 4'h2
`define CSFT_DIV_MID 4'h8
`define CSFT_DIV_LOW 4'h2
`define CSFT_MODE_HIGH 2'h0
`define CSFT_MODE_MID 2'h1
`define CSFT_MODE_LOW 2'h2
`define CSFT_OP_CYCLES 4'h2
`endif

// file: testbench/csft_core_checker.sv
// Port-level assertions for csft_core, attached by bind.
// Assumes the register map and operation codes of csft_consts.vh.
`timescale 1ns/100ps
`include "csft_consts.vh"
module csft_core_checker (
  // Clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // APB
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  // Core side
  input wire irq_req_i,
  input wire irq_take_o,
  input wire phi_en_o,
  input wire busy_o,
  input wire [7:0] port_dir_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire ap = psel_i && penable_i;
  wire dir_wr = ap && pwrite_i && paddr_i == `CSFT_ADDR_DIR;
  property p_irq_mask; irq_take_o |-> irq_req_i; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq taken without request");
  property p_reset_masked; $rose(rstn_i) ##0 irq_req_i |-> !irq_take_o; endproperty
  a_reset_masked: assert property (p_reset_masked) else $error("irq taken after reset");
  property p_dir_read; ap && !pwrite_i && paddr_i == `CSFT_ADDR_DIR |-> prdata_o == 32'h0;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction register readable");
  property p_dir_write; dir_wr |=> port_dir_o == $past(pwdata_i[7:0]); endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");
  property p_dir_hold; !dir_wr |=> $stable(port_dir_o); endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction changed unasked");
  property p_phi_pulse; phi_en_o |=> !phi_en_o; endproperty
  a_phi_pulse: assert property (p_phi_pulse) else $error("internal clock pulse too long");
  property p_op_start;
    ap && pwrite_i && paddr_i == `CSFT_ADDR_CTRL && pwdata_i[3:0] != 4'h0 && !busy_o |=> busy_o;
  endproperty
  a_op_start: assert property (p_op_start) else $error("operation did not start");
  property p_op_len; $rose(busy_o) |-> busy_o [*2] ##[1:60] !busy_o; endproperty
  a_op_len: assert property (p_op_len) else $error("operation length wrong");
endmodule // csft_core_checker
bind csft_core csft_core_checker chk_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .irq_req_i(irq_req_i), .irq_take_o(irq_take_o),
  .phi_en_o(phi_en_o), .busy_o(busy_o), .port_dir_o(port_dir_o));

// file: testbench/test_cpu_status_flags_and_timing.sv
// Self-checking bench for csft_core: APB calls with expected values.
// Main tick every cycle, sub tick every fourth cycle; no partner model.
`timescale 1ns/100ps
`include "csft_consts.vh"
module test_cpu_status_flags_and_timing;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg psel = 1'b0;
  reg pen = 1'b0;
  reg pwr = 1'b0;
  reg [11:0] pa = 12'h000;
  reg [31:0] pd = 32'h0;
  reg irq = 1'b1;
  reg [1:0] tc = 2'h0;
  reg [1:0] mode = 2'h0;
  reg [31:0] r;
  reg se = 1'b0;
  wire [31:0] prdata;
  wire pready, take, phi, busy, err;
  wire [7:0] dir;
  integer miscompares = 0;
  integer checks_done = 0;
  integer n, m;
  always #25 clk = ~clk;
  always @(posedge clk) tc <= tc + 2'h1;
  csft_core dut_u (.sys_clk_i(clk), .rstn_i(rstn), .main_oscillator_input_i(1'b1),
    .sub_oscillator_input_i(tc == 2'h0), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pd), .prdata_o(prdata), .pready_o(pready), .pslverr_o(err),
    .irq_req_i(irq), .irq_take_o(take), .phi_en_o(phi), .busy_o(busy), .port_dir_o(dir));
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e)
      begin
        miscompares = miscompares + 1;
        $display("BAD %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task tmo(input integer k);
    if (k > 40)
    begin
      miscompares = miscompares + 1;
      final_report;
    end
  endtask
  // The request is held until pready is seen high at a rising edge.
  task xf(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      k = 0;
      while (pready !== 1'b1)
      begin
        k = k + 1;
        tmo(k);
        @(posedge clk);
      end
      r = prdata;
      se = err;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task rc(input string nm, input [11:0] a, input [31:0] mk, input [31:0] e);
    begin
      xf(1'b0, a, 32'h0);
      chk(nm, r & mk, e);
    end
  endtask
  task op(input [3:0] o);
    integer k;
    begin
      xf(1'b1, `CSFT_ADDR_CTRL, {22'h0, mode, 4'h0, o});
      k = 0;
      r = 32'h10;
      while (r[4] !== 1'b0)
      begin
        k = k + 1;
        tmo(k);
        xf(1'b0, `CSFT_ADDR_CTRL, 32'h0);
      end
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rc("status", `CSFT_ADDR_STATUS, 32'hff, 32'h04);
    chk("take", take, 32'h0);
    op(4'hb);
    chk("take", take, 32'h1);
    rc("irq_en", `CSFT_ADDR_IRQ, 32'h1, 32'h1);
    irq <= 1'b0;
    @(posedge clk);
    chk("take_off", take, 32'h0);
    irq <= 1'b1;
    op(4'hc);
    rc("irq_dis", `CSFT_ADDR_IRQ, 32'h1, 32'h0);
    $display("test reset done");
    xf(1'b1, `CSFT_ADDR_RESULT, 32'h58);
    xf(1'b1, `CSFT_ADDR_OPND, 32'h46);
    op(4'h6);
    op(4'h3);
    op(4'h1);
    rc("dec_add", `CSFT_ADDR_RESULT, 32'hff, 32'h04);
    rc("carry", `CSFT_ADDR_STATUS, 32'h09, 32'h09);
    op(4'hc);
    op(4'h5);
    xf(1'b1, `CSFT_ADDR_RESULT, 32'h12);
    xf(1'b1, `CSFT_ADDR_OPND, 32'h21);
    op(4'h2);
    rc("dec_sub", `CSFT_ADDR_RESULT, 32'hff, 32'h91);
    rc("borrow", `CSFT_ADDR_STATUS, 32'h09, 32'h08);
    op(4'hc);
    op(4'h4);
    op(4'h6);
    xf(1'b1, `CSFT_ADDR_RESULT, 32'h58);
    xf(1'b1, `CSFT_ADDR_OPND, 32'h46);
    op(4'h1);
    rc("bin_add", `CSFT_ADDR_RESULT, 32'hff, 32'h9e);
    rc("bin_flags", `CSFT_ADDR_STATUS, 32'hff, 32'hc4);
    $display("test decimal done");
    op(4'h3);
    xf(1'b1, `CSFT_ADDR_RESULT, 32'h12);
    xf(1'b1, `CSFT_ADDR_OPND, 32'h10);
    op(4'h7);
    rc("mul", `CSFT_ADDR_RESULT, 32'hffff, 32'h0120);
    rc("mul_st", `CSFT_ADDR_STATUS, 32'hff, 32'hcc);
    xf(1'b1, `CSFT_ADDR_RESULT, 32'h37);
    xf(1'b1, `CSFT_ADDR_OPND, 32'h00);
    op(4'h8);
    rc("div", `CSFT_ADDR_RESULT, 32'hffff, 32'h37ff);
    rc("div_st", `CSFT_ADDR_STATUS, 32'hff, 32'hcc);
    $display("test muldiv done");
    op(4'h9);
    rc("sp", `CSFT_ADDR_SP, 32'hff, 32'hfe);
    rc("stack", `CSFT_ADDR_STACK, 32'hef, 32'hcc);
    op(4'h4);
    op(4'ha);
    rc("pulled", `CSFT_ADDR_STATUS, 32'hef, 32'hcc);
    rc("sp", `CSFT_ADDR_SP, 32'hff, 32'hff);
    xf(1'b1, `CSFT_ADDR_DIR, 32'ha5);
    rc("dir_rd", `CSFT_ADDR_DIR, 32'hffffffff, 32'h0);
    chk("dir", {24'h0, dir}, 32'ha5);
    rc("unmapped", 12'h0f0, 32'hffffffff, 32'h0);
    chk("slverr", {31'h0, se}, 32'h0);
    $display("test stack done");
    for (m = 0; m < 3; m = m + 1)
    begin
      mode = m[1:0];
      op(4'h0);
      repeat (16) @(negedge clk);
      n = 0;
      repeat (80)
      begin
        @(negedge clk);
        if (phi === 1'b1)
          n = n + 1;
      end
      chk("phi", n, (m == 0) ? 32'd40 : 32'd10);
    end
    $display("test clock done");
    final_report;
  end
endmodule // test_cpu_status_flags_and_timing
